// file: verilog/icc_pkg.sv
/*
  Shared constants, register layout and carrier types of the four-channel
  input capture unit. Assumes one 200 MHz clock and a Wishbone slave
  with 32-bit data.
*/
package icc_pkg;

  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int DEPTH = 4;

  // Word index of the register behind wb_adr_i[5:2]
  localparam logic [3:0] IDX_STAT = 4'h8;
  localparam logic [3:0] IDX_MASK = 4'h9;
  localparam logic IDX_SEL_BUF = 1'h0;
  localparam logic IDX_SEL_CON = 1'h1;
  localparam int IDX_HI = 3;
  localparam int ADR_LSB = 2;
  localparam int ADR_MSB = 5;

  // Control register field positions
  localparam int CON_MODE_LSB = 0;
  localparam int CON_BNE_BIT = 3;
  localparam int CON_OV_BIT = 4;
  localparam int CON_ICI_LSB = 5;
  localparam int CON_TSEL_BIT = 7;

  // Capture mode encodings
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_BOTH = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_WAKE = 3'h7;

  // Prescaler terminal counts and buffer-full count
  localparam logic [3:0] PRE_TC4 = 4'h3;
  localparam logic [3:0] PRE_TC16 = 4'hF;
  localparam logic [2:0] CNT_FULL = 3'h4;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] ICI_RST = 2'h0;
  localparam logic TSEL_RST = 1'h0;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] ici;
    logic tsel;
    logic ov;
    logic [2:0] cnt;
    logic [1:0] rptr;
    logic [1:0] wptr;
    logic [3:0] pre;
    logic [1:0] evc;
  } icc_chan_s;

  typedef struct packed {
    logic en;
    logic [1:0] addr;
    logic [DW-1:0] data;
  } icc_wr_s;

endpackage

// file: verilog/icc_buf_mem.sv
/*
  Four-word capture store of one channel, one write port and a registered
  read port. Assumes the caller keeps the read pointer stable for a cycle
  before the data is used.
*/
module icc_buf_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire icc_pkg::icc_wr_s wr_i,
  // Read side
  input wire logic [1:0] rd_addr_i,
  output logic [icc_pkg::DW-1:0] rd_data_o
);

  typedef struct packed {
    logic [icc_pkg::DEPTH-1:0][icc_pkg::DW-1:0] mem;
    logic [icc_pkg::DW-1:0] rdata;
  } icc_mem_state_s;

  icc_mem_state_s q;
  icc_mem_state_s d;

  always_comb begin
    d = q;
    if (wr_i.en) begin
      d.mem[wr_i.addr] = wr_i.data;
    end
    // A store into an empty buffer is readable in the very next cycle
    if (wr_i.en && wr_i.addr == rd_addr_i) begin
      d.rdata = wr_i.data;
    end else begin
      d.rdata = q.mem[rd_addr_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data_o = q.rdata;

endmodule

// file: verilog/icc_sync.sv
/*
  Two-stage synchroniser and edge detector for the capture pins.
  Assumes the pins are asynchronous to clk_i.
*/
module icc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic [icc_pkg::NCH-1:0] pin_i,
  // Edges, one cycle each
  output logic [icc_pkg::NCH-1:0] rise_o,
  output logic [icc_pkg::NCH-1:0] fall_o
);

  typedef struct packed {
    logic [icc_pkg::NCH-1:0] s1;
    logic [icc_pkg::NCH-1:0] s2;
    logic [icc_pkg::NCH-1:0] s3;
  } icc_sync_state_s;

  icc_sync_state_s q;
  icc_sync_state_s d;

  // Edges look only at the second and third stage
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;

endmodule

// file: verilog/icc_top.sv
/*
  Four-channel input capture unit with a classic Wishbone slave, sticky
  interrupt status, mask and a wake output. Assumes both timer counts
  come from logic on clk_i and the capture pins are asynchronous.
*/
// What this block does
// RQ1: Four independent channels, each fully self-contained.
// RQ2: Falling, rising, 4th, 16th rising, both edges.
// RQ3: Mode field sits in control bits 2:0.
// RQ4: Mode field also picks edge prescaler setting.
// RQ5: Switching channel off clears its prescaler.
// RQ6: Any reset clears every prescaler counter.
// RQ7: Four-entry, 16-bit capture FIFO per channel.
// RQ8: Not-empty flag set until all entries read.
// RQ9: Each read returns oldest, rest advance.
// RQ10: Capture with four held sets overflow flag.
// RQ11: Overflowing capture value is discarded.
// RQ12: After overflow ignore captures until drained.
// RQ13: Software never reads an empty buffer.
// RQ14: Bit 7 picks timer; second timer default.
// RQ15: Both-edge mode flags every edge, no overflow.
// RQ16: Bits 6:5 set captures per interrupt.
// RQ17: Mode 111 is rising-edge interrupt and wake.
// RQ18: Synchronised edge stores selected timer count.
// RQ19: Mode zero captures nothing, prescaler held clear.
module icc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [icc_pkg::ADR_MSB:icc_pkg::ADR_LSB] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Time bases
  input wire logic [icc_pkg::DW-1:0] timer_a_i,
  input wire logic [icc_pkg::DW-1:0] timer_b_i,
  // Capture pins
  input wire logic [icc_pkg::NCH-1:0] cap_pin_i,
  // Interrupt and wake
  output logic irq_o,
  output logic wake_o
);

  typedef struct packed {
    icc_pkg::icc_chan_s [icc_pkg::NCH-1:0] ch;
    logic [icc_pkg::NCH-1:0] stat;
    logic [icc_pkg::NCH-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic wake;
  } icc_state_s;

  icc_state_s q;
  icc_state_s d;

  logic [icc_pkg::NCH-1:0] rise;
  logic [icc_pkg::NCH-1:0] fall;
  icc_pkg::icc_wr_s [icc_pkg::NCH-1:0] wr;
  logic [icc_pkg::NCH-1:0][icc_pkg::DW-1:0] rd_data;

  // True when the word index addresses register kind sel of channel ch
  function automatic logic chan_hit(input logic [3:0] idx, input int ch,
                                    input logic sel);
    chan_hit = !idx[icc_pkg::IDX_HI] && (idx[2:1] == 2'(ch))
               && (idx[0] == sel);
  endfunction

  // Whether this edge qualifies for the mode and prescaler count
  function automatic logic qualify(input logic [2:0] mode,
                                   input logic [3:0] pre,
                                   input logic rise_in, input logic fall_in);
    unique case (mode)
      icc_pkg::MODE_BOTH: qualify = rise_in | fall_in;
      icc_pkg::MODE_FALL: qualify = fall_in;
      icc_pkg::MODE_RISE: qualify = rise_in;
      icc_pkg::MODE_RISE4: qualify = rise_in && pre == icc_pkg::PRE_TC4;
      icc_pkg::MODE_RISE16: qualify = rise_in && pre == icc_pkg::PRE_TC16;
      icc_pkg::MODE_WAKE: qualify = rise_in;
      default: qualify = 1'b0;
    endcase
  endfunction

  // Next prescaler count; held clear outside the divided modes
  function automatic logic [3:0] pre_next(input logic [2:0] mode,
                                          input logic [3:0] pre,
                                          input logic rise_in);
    logic [3:0] tc;
    tc = (mode == icc_pkg::MODE_RISE4) ? icc_pkg::PRE_TC4
                                       : icc_pkg::PRE_TC16;
    if (mode != icc_pkg::MODE_RISE4 && mode != icc_pkg::MODE_RISE16) begin
      pre_next = '0;
    end else if (!rise_in) begin
      pre_next = pre;
    end else if (pre == tc) begin
      pre_next = '0;
    end else begin
      pre_next = pre + 4'h1;
    end
  endfunction

  // Control word as software reads it
  function automatic logic [31:0] con_word(input icc_pkg::icc_chan_s c);
    logic [31:0] w;
    w = '0;
    w[icc_pkg::CON_MODE_LSB +: 3] = c.mode;
    w[icc_pkg::CON_BNE_BIT] = (c.cnt != 3'h0);
    w[icc_pkg::CON_OV_BIT] = c.ov;
    w[icc_pkg::CON_ICI_LSB +: 2] = c.ici;
    w[icc_pkg::CON_TSEL_BIT] = c.tsel;
    con_word = w;
  endfunction

  icc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(cap_pin_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  for (genvar g = 0; g < icc_pkg::NCH; g++) begin : g_mem
    icc_buf_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr[g]),
      .rd_addr_i(q.ch[g].rptr),
      .rd_data_o(rd_data[g])
    );
  end

  always_comb begin
    logic req;
    logic wr_req;
    logic rd_req;
    logic [3:0] idx;
    logic [icc_pkg::NCH-1:0] flag_set;
    logic [icc_pkg::NCH-1:0] wake_mode;
    logic qual;
    logic capture;
    logic full;
    logic store;
    logic pop;
    logic flag_ev;
    icc_pkg::icc_chan_s c;
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr_req = req & wb_we_i & wb_sel_i[0];
    rd_req = req & ~wb_we_i;
    idx = wb_adr_i;
    flag_set = '0;
    wake_mode = '0;
    qual = 1'b0;
    capture = 1'b0;
    full = 1'b0;
    store = 1'b0;
    pop = 1'b0;
    flag_ev = 1'b0;
    c = '0;
    d = q;
    wr = '0;
    d.ack = req;
    d.dat = '0;
    // Per-channel logic, each channel with its own state [RQ1]
    for (int ch = 0; ch < icc_pkg::NCH; ch++) begin
      c = q.ch[ch];
      qual = qualify(c.mode, c.pre, rise[ch], fall[ch]); // [RQ2] [RQ4]
      d.ch[ch].pre = pre_next(c.mode, c.pre, rise[ch]); // [RQ5] [RQ19]
      // Wake mode raises a flag only, nothing is stored [RQ17]
      capture = qual && c.mode != icc_pkg::MODE_WAKE;
      full = (c.cnt == icc_pkg::CNT_FULL);
      store = capture && !full && !c.ov; // [RQ11] [RQ12]
      // Both-edge mode drops silently when full [RQ15]
      if (capture && full && c.mode != icc_pkg::MODE_BOTH) begin
        d.ch[ch].ov = 1'b1; // [RQ10]
      end
      // Empty reads do not move the pointer; data is stale [RQ13]
      pop = rd_req && chan_hit(idx, ch, icc_pkg::IDX_SEL_BUF)
            && c.cnt != 3'h0;
      // Selected timer count goes in at the write pointer [RQ18] [RQ14]
      wr[ch].en = store;
      wr[ch].addr = c.wptr;
      wr[ch].data = c.tsel ? timer_a_i : timer_b_i; // [RQ7]
      if (store) begin
        d.ch[ch].wptr = c.wptr + 2'h1;
      end
      if (pop) begin
        d.ch[ch].rptr = c.rptr + 2'h1; // [RQ9]
        // Last entry gone re-arms capture after overflow [RQ12]
        if (c.cnt == 3'h1) begin
          d.ch[ch].ov = 1'b0;
        end
      end
      d.ch[ch].cnt = c.cnt + {2'h0, store} - {2'h0, pop}; // [RQ8]
      // Interrupt after ici+1 stored captures; in both-edge and wake mode on every qualifying edge [RQ16]
      if (c.mode == icc_pkg::MODE_BOTH || c.mode == icc_pkg::MODE_WAKE) begin
        flag_ev = qual; // [RQ15] [RQ17]
        d.ch[ch].evc = '0;
      end else if (store && c.evc == c.ici) begin
        flag_ev = 1'b1;
        d.ch[ch].evc = '0;
      end else if (store) begin
        flag_ev = 1'b0;
        d.ch[ch].evc = c.evc + 2'h1;
      end else begin
        flag_ev = 1'b0;
      end
      flag_set[ch] = flag_ev;
      wake_mode[ch] = (c.mode == icc_pkg::MODE_WAKE);
      // Control write takes mode, interrupt count and timer select [RQ3]
      if (wr_req && chan_hit(idx, ch, icc_pkg::IDX_SEL_CON)) begin
        d.ch[ch].mode = wb_dat_i[icc_pkg::CON_MODE_LSB +: 3];
        d.ch[ch].ici = wb_dat_i[icc_pkg::CON_ICI_LSB +: 2];
        d.ch[ch].tsel = wb_dat_i[icc_pkg::CON_TSEL_BIT];
      end
      // Turning off drops the prescaler and count of events [RQ5]
      if (d.ch[ch].mode == icc_pkg::MODE_OFF) begin
        d.ch[ch].pre = '0;
        d.ch[ch].evc = '0;
      end
      if (rd_req && chan_hit(idx, ch, icc_pkg::IDX_SEL_BUF)) begin
        d.dat = {16'h0000, rd_data[ch]};
      end
      if (rd_req && chan_hit(idx, ch, icc_pkg::IDX_SEL_CON)) begin
        d.dat = con_word(c);
      end
    end
    // Sticky status: a new event wins over a write-one clear
    if (wr_req && idx == icc_pkg::IDX_STAT) begin
      d.stat = q.stat & ~wb_dat_i[icc_pkg::NCH-1:0];
    end
    d.stat = d.stat | flag_set;
    if (wr_req && idx == icc_pkg::IDX_MASK) begin
      d.mask = wb_dat_i[icc_pkg::NCH-1:0];
    end
    if (rd_req && idx == icc_pkg::IDX_STAT) begin
      d.dat = {28'h0000000, q.stat};
    end
    if (rd_req && idx == icc_pkg::IDX_MASK) begin
      d.dat = {28'h0000000, q.mask};
    end
    d.irq = |(d.stat & d.mask);
    d.wake = |(d.stat & d.mask & wake_mode); // [RQ17]
  end

  // Synchronous reset clears every prescaler with the rest [RQ6]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      for (int ch = 0; ch < icc_pkg::NCH; ch++) begin
        q.ch[ch].mode <= icc_pkg::MODE_RST;
        q.ch[ch].ici <= icc_pkg::ICI_RST;
        q.ch[ch].tsel <= icc_pkg::TSEL_RST;
      end
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;
  assign wake_o = q.wake;

endmodule

// file: verif/icc_properties.sv
/*
  Port checker of the capture unit.
  Assumes it is bound to icc_top and sees only its ports.
*/
module icc_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [icc_pkg::ADR_MSB:icc_pkg::ADR_LSB] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Time bases
  input wire logic [icc_pkg::DW-1:0] timer_a_i,
  input wire logic [icc_pkg::DW-1:0] timer_b_i,
  // Capture pins
  input wire logic [icc_pkg::NCH-1:0] cap_pin_i,
  // Interrupt and wake
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Eight quiet cycles outlast the synchroniser and the flag register
  sequence quiet_s;
    ($stable(cap_pin_i) && !wb_cyc_i && !wb_ack_o)[*8];
  endsequence
  ack_next_a: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property ((!wb_ack_o || wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("read data outside read ack");
  wake_irq_a: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt");
  irq_quiet_a: assert property (quiet_s |=> !$rose(irq_o) && !$rose(wake_o))
    else $error("interrupt without cause");
  irq_hold_a: assert property ($fell(irq_o) |-> wb_ack_o ||
    $past(wb_ack_o) || $past(rst_i) || $past(rst_i, 2))
    else $error("interrupt dropped without write");
  mask_off_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == icc_pkg::IDX_MASK && wb_dat_i[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt despite zero mask");
endmodule

bind icc_top icc_properties u_icc_properties (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_a_i(timer_a_i),
  .timer_b_i(timer_b_i), .cap_pin_i(cap_pin_i), .irq_o(irq_o),
  .wake_o(wake_o));

// file: verif/icc_pin_drv.sv
/*
  Model of the signals on the four capture pins.
  Assumes push-pull sources, so a pin is never released.
*/
module icc_pin_drv (
  // Clock
  input wire logic clk_i,
  // Pins
  output logic [icc_pkg::NCH-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 4'h0;
  // Each level is held past the synchroniser and capture latency
  task automatic set(input int ch, input logic v);
    @(posedge clk_i);
    pin_o[ch] <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse(input int ch);
    set(ch, 1'b1);
    set(ch, 1'b0);
  endtask
endmodule

// file: verif/testbench.sv
/*
  Self-checking bench of the capture unit.
  Assumes icc_top, the pin model and the bound checker.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hF, pins;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, irq, wake;
  logic [15:0] tma = 16'hFFFF, tmb = 16'h0;
  int miscompares = 0, checked = 0, cycles = 0;
  icc_top u_icc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timer_a_i(tma),
    .timer_b_i(tmb), .cap_pin_i(pins), .irq_o(irq), .wake_o(wake));
  icc_pin_drv u_icc_pin_drv (.clk_i(clk_i), .pin_o(pins));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hang in a bus wait ends here
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic t_reset();
    for (int c = 0; c < 4; c++) rd(4'(2 * c + 1), 32'h0);
    rd(icc_pkg::IDX_STAT, 32'h0);
    bus(1'b1, 4'hA, 32'hFF);
    rd(4'hA, 32'h0);
  endtask
  task automatic t_fifo();
    bus(1'b1, 4'h1, 32'h23);
    for (int i = 1; i <= 5; i++) begin
      @(posedge clk_i);
      tmb <= 16'(i);
      u_icc_pin_drv.pulse(0);
      if (i < 3) rd(icc_pkg::IDX_STAT, 32'(i - 1));
    end
    rd(4'h1, 32'h3B);
    // Every buffer read below finds an entry waiting
    for (int i = 1; i <= 3; i++) rd(4'h0, 32'(i));
    @(posedge clk_i);
    tmb <= 16'h0009;
    u_icc_pin_drv.pulse(0);
    rd(4'h0, 32'h4);
    rd(4'h1, 32'h23);
    @(posedge clk_i);
    tmb <= 16'h0006;
    u_icc_pin_drv.pulse(0);
    rd(4'h0, 32'h6);
    bus(1'b1, 4'h1, 32'h0);
    bus(1'b1, icc_pkg::IDX_STAT, 32'hF);
  endtask
  // Two stray edges before the clear would complete a count early
  task automatic t_pre(input int ch, input logic [2:0] m, input int n,
                       input logic hard);
    logic [3:0] ca;
    ca = 4'(2 * ch + 1);
    bus(1'b1, ca, 32'h80 | 32'(m));
    u_icc_pin_drv.pulse(ch);
    u_icc_pin_drv.pulse(ch);
    if (hard) begin
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
    end else bus(1'b1, ca, 32'h80);
    bus(1'b1, ca, 32'h80 | 32'(m));
    @(posedge clk_i);
    tma <= 16'hA5A5;
    repeat (n - 1) u_icc_pin_drv.pulse(ch);
    rd(ca, 32'h80 | 32'(m));
    u_icc_pin_drv.pulse(ch);
    rd(ca, 32'h88 | 32'(m));
    rd(ca - 4'h1, 32'hA5A5);
    bus(1'b1, ca, 32'h0);
  endtask
  task automatic t_irq();
    @(posedge clk_i);
    tmb <= 16'h1234;
    bus(1'b1, 4'h5, 32'h2);
    u_icc_pin_drv.set(2, 1'b1);
    rd(4'h5, 32'h2);
    u_icc_pin_drv.set(2, 1'b0);
    rd(4'h5, 32'hA);
    rd(4'h4, 32'h1234);
    bus(1'b1, icc_pkg::IDX_STAT, 32'hF);
    bus(1'b1, icc_pkg::IDX_MASK, 32'h4);
    bus(1'b1, 4'h5, 32'h61);
    u_icc_pin_drv.set(2, 1'b1);
    chk(32'(irq), 32'h1);
    bus(1'b1, icc_pkg::IDX_MASK, 32'h0);
    @(posedge clk_i);
    chk(32'(irq), 32'h0);
    bus(1'b1, icc_pkg::IDX_MASK, 32'h4);
    bus(1'b1, icc_pkg::IDX_STAT, 32'h4);
    @(posedge clk_i);
    chk(32'(irq), 32'h0);
    // Six edges in all overrun the buffer without an overflow
    repeat (3) u_icc_pin_drv.pulse(2);
    rd(4'h5, 32'h69);
    bus(1'b1, icc_pkg::IDX_MASK, 32'h8);
    bus(1'b1, 4'h7, 32'h7);
    u_icc_pin_drv.pulse(3);
    chk(32'(wake), 32'h1);
    rd(4'h7, 32'h7);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fifo();
    t_pre(1, icc_pkg::MODE_RISE4, 4, 1'b0);
    t_pre(3, icc_pkg::MODE_RISE16, 16, 1'b1);
    t_irq();
    conclude();
  end
endmodule
